/* logic/dll_powerup_init_sequence.sv */
// delay-locked loop enable, lock interval and relock tracking
// Function
// - after disable rises, lock declared only after 1024 reference cycles
// - loop reference is input clock pair or output clock pair
// - loop lock is only valid for reference frequency 80 MHz and above; code drops lock for reference edges over 2 system cycles apart
// - frequency change drops lock; a window-check change keeps the locked state, a slower reference trips the stop check and restarts the 1024-cycle count
`timescale 1ns/1ps
`default_nettype none
module dll_powerup_init_sequence (
   // system clocking
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic clkEn,
   // device pins
   input  wire logic dll_disable_n,
   input  wire logic inClk,
   input  wire logic outClk,
   input  wire logic refSelOut,
   // loop status
   output logic      dllLocked,
   output logic      dllActive,
   output logic      dllReset
);
   typedef struct packed {
      dll_init_pkg::dll_state_t fsm;
      logic [10:0]              lockCnt;
      logic [3:0]               gapCnt;
      logic [7:0]               winCnt;
      logic [8:0]               edgeCnt;
      logic [8:0]               refRate;
      logic                     rateValid;
      logic                     locked;
      logic                     active;
      logic                     rstPulse;
   } dll_ctl_t;
   dll_ctl_t st_r;
   dll_ctl_t st_nxt;

   logic enSync;
   logic inRise;
   logic outRise;
   logic selSync;

   // all pins cross into clk through two flops
   edge_sync uEn (
      .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .asyncIn(dll_disable_n), .syncOut(enSync), .risePulse());
   edge_sync uIn (
      .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .asyncIn(inClk), .syncOut(), .risePulse(inRise));
   edge_sync uOut (
      .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .asyncIn(outClk), .syncOut(), .risePulse(outRise));
   edge_sync uSel (
      .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .asyncIn(refSelOut), .syncOut(selSync), .risePulse());

   // reference edge from the selected clock pair
   logic refEdge;
   assign refEdge = selSync ? outRise : inRise;

   // absolute difference of two rate samples
   function automatic logic [8:0] absDiff(input logic [8:0] a,
                                          input logic [8:0] b);
      absDiff = (a > b) ? 9'(a - b) : 9'(b - a);
   endfunction

   logic rateJump;
   logic stopSeen;

   always_comb begin
      st_nxt          = st_r;
      st_nxt.rstPulse = 1'b0;
      rateJump        = 1'b0;
      // gap counter: cycles since last reference edge, saturating
      if (refEdge) begin
         st_nxt.gapCnt = '0;
      end else if (st_r.gapCnt != 4'hf) begin
         st_nxt.gapCnt = 4'(st_r.gapCnt + 4'h1);
      end
      // 30 ns stop of the reference counts as a loop reset
      stopSeen = (st_r.gapCnt >= dll_init_pkg::STOP_LAST) && !refEdge;
      // windowed edge rate, a change beyond tolerance is a new frequency
      st_nxt.winCnt = 8'(st_r.winCnt + 8'h1);
      if (refEdge) begin
         st_nxt.edgeCnt = 9'(st_r.edgeCnt + 9'h1);
      end
      if (st_r.winCnt == dll_init_pkg::WIN_LAST) begin
         st_nxt.edgeCnt   = '0;
         st_nxt.refRate   = st_r.edgeCnt;
         st_nxt.rateValid = 1'b1;
         rateJump = st_r.rateValid &&
            (absDiff(st_r.edgeCnt, st_r.refRate) > dll_init_pkg::FREQ_TOL);
      end
      unique case (st_r.fsm)
         // disabled: no progress at all
         dll_init_pkg::ST_OFF: begin
            st_nxt.lockCnt = '0;
            st_nxt.locked  = 1'b0;
            st_nxt.active  = 1'b0;
            if (enSync) begin
               st_nxt.fsm    = dll_init_pkg::ST_LOCKNG;
               st_nxt.active = 1'b1;
            end
         end
         // count reference edges until lock
         dll_init_pkg::ST_LOCKNG: begin
            if (refEdge) begin
               st_nxt.lockCnt = 11'(st_r.lockCnt + 11'h1);
               if (st_r.lockCnt == dll_init_pkg::LOCK_LAST) begin
                  st_nxt.fsm    = dll_init_pkg::ST_LOCKED;
                  st_nxt.locked = 1'b1;
               end
            end
         end
         // locked: watch for a stop or a frequency change
         dll_init_pkg::ST_LOCKED: begin
            // a reference slower than the floor leaves a long gap
            if (rateJump ||
                (st_r.gapCnt >= dll_init_pkg::SLOW_LAST && !refEdge)) begin
               st_nxt.locked = 1'b0;
            end
         end
         // reference stopped: loop is held in reset
         dll_init_pkg::ST_STOPPD: begin
            st_nxt.lockCnt  = '0;
            st_nxt.locked   = 1'b0;
            st_nxt.rstPulse = 1'b1;
            if (refEdge) begin
               st_nxt.fsm = dll_init_pkg::ST_LOCKNG;
            end
         end
      endcase
      // a stop resets the loop from any enabled state
      if (st_r.fsm != dll_init_pkg::ST_OFF && stopSeen) begin
         st_nxt.fsm     = dll_init_pkg::ST_STOPPD;
         st_nxt.lockCnt = '0;
         st_nxt.locked  = 1'b0;
      end
      // disable wins over everything but the reset pulse of the stopped state
      if (!enSync) begin
         st_nxt.fsm     = dll_init_pkg::ST_OFF;
         st_nxt.lockCnt = '0;
         st_nxt.locked  = 1'b0;
         st_nxt.active  = 1'b0;
      end
   end

   // single state register; clock enable freezes everything
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r     <= '0;
         st_r.fsm <= dll_init_pkg::ST_OFF;
      end else if (clkEn) begin
         st_r <= st_nxt;
      end
   end

   assign dllLocked = st_r.locked;
   assign dllActive = st_r.active;
   assign dllReset  = st_r.rstPulse;

   // no lock without the full count
   a_lock_needs_count: assert property (
      @(posedge clk) disable iff (sys_rst)
      $rose(dllLocked) |-> $past(st_r.lockCnt) == dll_init_pkg::LOCK_LAST)
      else $error("lock declared before full count");
   // a disabled loop makes no progress
   a_off_no_progress: assert property (
      @(posedge clk) disable iff (sys_rst)
      (clkEn && !enSync) |=> (st_r.lockCnt == '0 && !dllLocked))
      else $error("progress while disabled");
   // reference gone quiet while the loop is enabled
   sequence refStopped;
      clkEn && stopSeen && st_r.fsm != dll_init_pkg::ST_OFF && enSync;
   endsequence
   a_stop_resets: assert property (
      @(posedge clk) disable iff (sys_rst)
      refStopped |=> (st_r.fsm == dll_init_pkg::ST_STOPPD && !dllLocked))
      else $error("stop did not reset loop");
   // limitation: at the fastest sampled rate any slower reference shows
   // up as a stop first, so this guards the window check on its own
   a_jump_unlocks: assert property (
      @(posedge clk) disable iff (sys_rst)
      (clkEn && rateJump && st_r.fsm == dll_init_pkg::ST_LOCKED)
      |=> !dllLocked)
      else $error("frequency change kept lock");
   // a long gap while locked drops lock at once
   a_slow_unlocks: assert property (
      @(posedge clk) disable iff (sys_rst)
      (clkEn && dllLocked && st_r.gapCnt >= dll_init_pkg::SLOW_LAST &&
       !refEdge) |=> !dllLocked)
      else $error("slow reference kept lock");
   // only an edge of the chosen pair advances the lock count
   a_ref_select: assert property (
      @(posedge clk) disable iff (sys_rst)
      (clkEn && enSync && st_r.fsm == dll_init_pkg::ST_LOCKNG &&
       ((selSync && outRise) || (!selSync && inRise)) &&
       st_r.lockCnt != dll_init_pkg::LOCK_LAST)
      |=> st_r.lockCnt == 11'($past(st_r.lockCnt) + 11'h1))
      else $error("wrong reference pair");
   // a low clock enable freezes every state bit
   a_freeze_holds: assert property (
      @(posedge clk) disable iff (sys_rst)
      !clkEn |=> $stable(st_r))
      else $error("state moved while frozen");
endmodule
`default_nettype wire

/* common/dll_init_pkg.sv */
// constants for the delay-locked loop power-up and lock tracking block
`default_nettype none
package dll_init_pkg;
   // reference clock edges needed after enable before the loop is locked
   localparam int unsigned LOCK_CYCLES   = 1024;
   localparam int          LOCK_CW       = 11;
   localparam logic [10:0] LOCK_LAST     = 11'h3ff;
   // clock stop that resets the loop, in ns, and in system clock cycles
   localparam int unsigned STOP_NS       = 30;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned STOP_CYCLES   =
      (STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  STOP_LAST     = 4'(STOP_CYCLES - 1);
   // lowest supported reference frequency 80 MHz: period at most 12.5 ns
   localparam int unsigned MIN_FREQ_MHZ  = 80;
   // longest reference period in system cycles before the loop drops lock
   localparam logic [3:0]  SLOW_LAST     = 4'h1;
   // frequency check: reference edges per window of system cycles
   localparam logic [7:0]  WIN_LAST      = 8'hff;
   localparam logic [8:0]  FREQ_TOL      = 9'h004;
   typedef enum logic [1:0] {
      ST_OFF    = 2'b00,
      ST_LOCKNG = 2'b01,
      ST_LOCKED = 2'b11,
      ST_STOPPD = 2'b10
   } dll_state_t;
endpackage
`default_nettype wire

/* logic/edge_sync.sv */
// two-flop synchroniser with rising-edge pulse for the reference clock
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
   // clocking
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic clkEn,
   // asynchronous level and its synchronised forms
   input  wire logic asyncIn,
   output logic      syncOut,
   output logic      risePulse
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } sync_t;
   sync_t state_r;
   sync_t state_nxt;

   // the meta stage feeds only the sync stage
   always_comb begin
      state_nxt      = state_r;
      state_nxt.meta = asyncIn;
      state_nxt.sync = state_r.meta;
      state_nxt.last = state_r.sync;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= '0;
      end else if (clkEn) begin
         state_r <= state_nxt;
      end
   end

   assign syncOut   = state_r.sync;
   assign risePulse = state_r.sync & ~state_r.last;
endmodule
`default_nettype wire

/* verif/ctrl_model.sv */
// controller model: clock pairs and loop enable pin
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
   // clocking
   input  wire logic clk,
   input  wire logic sys_rst,
   // commands from the bench
   input  wire logic enReq,
   input  wire logic runIn,
   input  wire logic runOut,
   input  wire logic slow,
   // device pins
   output logic      dll_disable_n,
   output logic      inClk,
   output logic      outClk
);
   logic [1:0] div_r;
   logic [4:0] stable_r;
   // stopped clocks stand still; slow mode toggles every third cycle
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {div_r, stable_r, dll_disable_n, inClk, outClk} <= '0;
      end else begin
         div_r <= (slow && div_r != 2'h2) ? div_r + 2'h1 : 2'h0;
         if (div_r == 2'h0 && runIn) inClk <= !inClk;
         if (div_r == 2'h0 && runOut) outClk <= !outClk;
         if (stable_r != 5'h1f && (runIn || runOut))
            stable_r <= stable_r + 5'h1;
         // enable only once the clocks have run a while
         dll_disable_n <= enReq && stable_r == 5'h1f;
      end
   end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for loop enable, lock and relock
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, refSelOut = 1'b0;
   logic enReq = 1'b0, runIn = 1'b0, runOut = 1'b0, slow = 1'b0;
   logic dll_disable_n, inClk, outClk, dllLocked, dllActive, dllReset;
   logic lastLock = 1'b0, refPrev = 1'b0, refNow;
   logic expQ[$];
   int   error_cnt = 0, compares = 0, rises = 0, n;
   int   seed = 32'h7c47e186;
   always #10 clk = ~clk;
   dll_powerup_init_sequence i_dut (.clk(clk), .sys_rst(sys_rst),
      .clkEn(clkEn), .dll_disable_n(dll_disable_n), .inClk(inClk),
      .outClk(outClk), .refSelOut(refSelOut), .dllLocked(dllLocked),
      .dllActive(dllActive), .dllReset(dllReset));
   ctrl_model i_ctrl (.clk(clk), .sys_rst(sys_rst), .enReq(enReq),
      .runIn(runIn), .runOut(runOut), .slow(slow),
      .dll_disable_n(dll_disable_n), .inClk(inClk), .outClk(outClk));
   task automatic check(input logic seen, input logic exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: saw %b want %b", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // bounded wait; a miss leaves a note behind in the queue
   task automatic wait_lock(input logic v);
      for (int i = 0; i < 4000 && dllLocked !== v; i++) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask
   assign refNow = refSelOut ? outClk : inClk;
   // lock changes are matched against the oldest note
   always @(posedge clk) begin
      refPrev <= refNow;
      lastLock <= dllLocked;
      if (dllReset === 1'b1 || dll_disable_n !== 1'b1) rises <= 0;
      else if (refNow && !refPrev) rises <= rises + 1;
      if (!sys_rst && dllLocked !== lastLock) begin
         if (expQ.size() == 0) check(dllLocked, lastLock);
         else check(dllLocked, expQ.pop_front());
         if (dllLocked === 1'b1)
            check(rises >= 1024 && rises <= 1028, 1'b1);
      end
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      check(dllLocked, 1'b0);
      check(dllActive, 1'b0);
      runIn <= 1'b1;
      repeat (1500) @(posedge clk);
      check(dllActive, 1'b0);
      expQ.push_back(1'b1);
      enReq <= 1'b1;
      wait_lock(1'b1);
      check(dllActive, 1'b1);
      // freeze for an even count so the sampled reference keeps its phase
      clkEn <= 1'b0;
      repeat (2 * (4 + ($unsigned($random(seed)) % 8))) @(posedge clk);
      check(dllLocked, 1'b1);
      check(dllActive, 1'b1);
      clkEn <= 1'b1;
      // stop long enough to reset, resume on the output pair only
      expQ.push_back(1'b0);
      n = 8 + ($unsigned($random(seed)) % 4);
      runIn <= 1'b0;
      repeat (n) @(posedge clk);
      check(dllReset, 1'b1);
      expQ.push_back(1'b1);
      refSelOut <= 1'b1;
      runOut <= 1'b1;
      wait_lock(1'b0);
      wait_lock(1'b1);
      // too slow a reference loses lock
      expQ.push_back(1'b0);
      slow <= 1'b1;
      wait_lock(1'b0);
      enReq <= 1'b0;
      repeat (10) @(posedge clk);
      check(dllActive, 1'b0);
      check(expQ.size() == 0, 1'b1);
      close_out();
   end
   // run needs about 6000 cycles; allow over three times that
   initial begin
      #(20 * 20000);
      error_cnt++;
      close_out();
   end
endmodule
`default_nettype wire
